/* File: verilog/tcs_timer_select.sv */
// Six-channel count source and counter clear selector with APB registers
// What this block does
// - Two clear bits pick none, A, B, sync
// - Top clear bit reserved on narrow channels
// - Sync clear only with channel sync bit set
// - Buffered C or D never clears counter
// - Channel 0 sources: phi/1..64, pins A-D
// - Channel 1: pins A,B, phi/256, ch2 overflow
// - Channel 2: phi/1, pins A-C, internal others
// - Channel 3: pin A, phi/1024, 256, 4096
// - Channel 4: pins A,C, phi/1024, ch5 overflow
// - Channel 5: pins A,C,D, phi/256, internal
// - Phase counting mode overrides source select
// - Channels 0,3 add C, D clear codes
// - Edge select rise, fall or both
`include "tcs_defs.svh"

module tcs_timer_select
    import tcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire tcs_pins_s   ext_pins_i,
    input  wire tcs_events_s match_i,
    input  wire logic [5:0]  ovf_i,
    output logic [5:0]       count_en_o,
    output logic [5:0]       clear_o,
    output logic [5:0]       phase_mode_o
);

    tcs_state_s state_r;
    tcs_state_s state_nxt;

    function automatic logic edge_hit(input logic cur, input logic prev,
                                      input logic [1:0] edge_sel);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        if (edge_sel[`TCS_EDGE_BOTH_BIT]) begin
            edge_hit = rise | fall;
        end else if (edge_sel == `TCS_EDGE_FALL) begin
            edge_hit = fall;
        end else begin
            edge_hit = rise;
        end
    endfunction : edge_hit

    function automatic tcs_src_e src_of(input int ch, input logic [2:0] psc);
        tcs_src_e low;
        unique case (psc[1:0])
            2'h0: low = TCS_SRC_DIV1;
            2'h1: low = TCS_SRC_DIV4;
            2'h2: low = TCS_SRC_DIV16;
            default: low = TCS_SRC_DIV64;
        endcase
        src_of = low;
        unique case (ch)
            0: begin
                if (psc[2]) begin
                    src_of = tcs_src_e'(4'(TCS_SRC_PINA) + 4'(psc[1:0]));
                end
            end
            1: begin
                unique case (psc)
                    3'h4: src_of = TCS_SRC_PINA;
                    3'h5: src_of = TCS_SRC_PINB;
                    3'h6: src_of = TCS_SRC_DIV256;
                    3'h7: src_of = TCS_SRC_OVF;
                    default: src_of = low;
                endcase
            end
            2: begin
                unique case (psc)
                    3'h1: src_of = `TCS_CH2_PSC1_SRC;
                    3'h2: src_of = `TCS_CH2_PSC2_SRC;
                    3'h3: src_of = `TCS_CH2_PSC3_SRC;
                    3'h4: src_of = TCS_SRC_PINA;
                    3'h5: src_of = TCS_SRC_PINB;
                    3'h6: src_of = TCS_SRC_PINC;
                    3'h7: src_of = `TCS_CH2_PSC7_SRC;
                    default: src_of = low;
                endcase
            end
            3: begin
                unique case (psc)
                    3'h4: src_of = TCS_SRC_PINA;
                    3'h5: src_of = TCS_SRC_DIV1024;
                    3'h6: src_of = TCS_SRC_DIV256;
                    3'h7: src_of = TCS_SRC_DIV4096;
                    default: src_of = low;
                endcase
            end
            4: begin
                unique case (psc)
                    3'h4: src_of = TCS_SRC_PINA;
                    3'h5: src_of = TCS_SRC_PINC;
                    3'h6: src_of = TCS_SRC_DIV1024;
                    3'h7: src_of = TCS_SRC_OVF;
                    default: src_of = low;
                endcase
            end
            default: begin
                unique case (psc)
                    3'h1: src_of = `TCS_CH5_PSC1_SRC;
                    3'h4: src_of = TCS_SRC_PINA;
                    3'h5: src_of = TCS_SRC_PINC;
                    3'h6: src_of = TCS_SRC_DIV256;
                    3'h7: src_of = TCS_SRC_PIND;
                    default: src_of = low;
                endcase
            end
        endcase
    endfunction : src_of

    logic [7:0] ctrl_addr [`TCS_NCH];
    logic       wr_en;
    logic       rd_setup;
    logic       addr_ok;
    logic [5:0] own_clr;
    logic       sync_any;
    logic [3:0] pins;

    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign pins     = {ext_pins_i.d, ext_pins_i.c, ext_pins_i.b, ext_pins_i.a};

    always_comb begin
        tcs_src_e   src;
        logic [1:0] edge_sel;
        logic [2:0] cclr;
        logic       tick;
        logic       bufc;
        logic       bufd;
        src       = TCS_SRC_DIV1;
        edge_sel  = `TCS_EDGE_RISE;
        cclr      = `TCS_CLR_NONE;
        tick      = 1'b0;
        bufc      = 1'b0;
        bufd      = 1'b0;
        state_nxt = state_r;
        addr_ok   = 1'b0;
        own_clr   = '0;
        sync_any  = 1'b0;
        for (int ch = 0; ch < `TCS_NCH; ch++) begin
            ctrl_addr[ch] = 8'(`TCS_OFF_CTRL_BASE + ch * `TCS_OFF_CTRL_STEP);
        end
        // Pin synchroniser; edges only use the second and third stages
        state_nxt.s1 = pins;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        // A single divider keeps equal ratios on all channels in phase
        state_nxt.div      = state_r.div + 12'h001;
        state_nxt.div_prev = state_r.div;

        // Clear causes per channel, before the sync group is merged
        for (int ch = 0; ch < `TCS_NCH; ch++) begin
            cclr = state_r.ctrl[ch][`TCS_CCLR_HI:`TCS_CCLR_LO];
            bufc = (ch == 0) ? state_r.mode[`TCS_MODE_BUFC0] :
                   (ch == 3) ? state_r.mode[`TCS_MODE_BUFC3] : 1'b0;
            bufd = (ch == 0) ? state_r.mode[`TCS_MODE_BUFD0] :
                   (ch == 3) ? state_r.mode[`TCS_MODE_BUFD3] : 1'b0;
            unique case (cclr)
                `TCS_CLR_A: own_clr[ch] = match_i.a[ch];
                `TCS_CLR_B: own_clr[ch] = match_i.b[ch];
                // Buffer use suppresses the C or D event entirely
                `TCS_CLR_C: own_clr[ch] = match_i.c[ch] & ~bufc;
                `TCS_CLR_D: own_clr[ch] = match_i.d[ch] & ~bufd;
                default:    own_clr[ch] = 1'b0;
            endcase
            sync_any = sync_any | (own_clr[ch] & state_r.sync[ch]);
        end
        for (int ch = 0; ch < `TCS_NCH; ch++) begin
            cclr = state_r.ctrl[ch][`TCS_CCLR_HI:`TCS_CCLR_LO];
            state_nxt.clr[ch] = own_clr[ch] |
                ((cclr[1:0] == `TCS_CLR_SYNC_LO) & state_r.sync[ch] &
                 sync_any);
        end

        // Count enable per channel
        for (int ch = 0; ch < `TCS_NCH; ch++) begin
            src      = src_of(ch, state_r.ctrl[ch][`TCS_PSC_HI:`TCS_PSC_LO]);
            edge_sel = state_r.ctrl[ch][`TCS_EDGE_HI:`TCS_EDGE_LO];
            unique case (src)
                TCS_SRC_DIV1:    tick = 1'b1;
                TCS_SRC_DIV4:    tick = edge_hit(state_r.div[`TCS_DIV4_BIT],
                    state_r.div_prev[`TCS_DIV4_BIT], edge_sel);
                TCS_SRC_DIV16:   tick = edge_hit(state_r.div[`TCS_DIV16_BIT],
                    state_r.div_prev[`TCS_DIV16_BIT], edge_sel);
                TCS_SRC_DIV64:   tick = edge_hit(state_r.div[`TCS_DIV64_BIT],
                    state_r.div_prev[`TCS_DIV64_BIT], edge_sel);
                TCS_SRC_DIV256:  tick = edge_hit(state_r.div[`TCS_DIV256_BIT],
                    state_r.div_prev[`TCS_DIV256_BIT], edge_sel);
                TCS_SRC_DIV1024: tick = edge_hit(state_r.div[`TCS_DIV1024_BIT],
                    state_r.div_prev[`TCS_DIV1024_BIT], edge_sel);
                TCS_SRC_DIV4096: tick = edge_hit(state_r.div[`TCS_DIV4096_BIT],
                    state_r.div_prev[`TCS_DIV4096_BIT], edge_sel);
                TCS_SRC_PINA:    tick = edge_hit(state_r.s2[0], state_r.s3[0],
                    edge_sel);
                TCS_SRC_PINB:    tick = edge_hit(state_r.s2[1], state_r.s3[1],
                    edge_sel);
                TCS_SRC_PINC:    tick = edge_hit(state_r.s2[2], state_r.s3[2],
                    edge_sel);
                TCS_SRC_PIND:    tick = edge_hit(state_r.s2[3], state_r.s3[3],
                    edge_sel);
                default:         tick = (ch == 1) ? ovf_i[2] : ovf_i[5];
            endcase
            state_nxt.cnt_en[ch] = tick & ~state_r.mode[ch];
        end

        // APB decode; read data is latched in the setup cycle
        for (int ch = 0; ch < `TCS_NCH; ch++) begin
            if (paddr_i == ctrl_addr[ch]) begin
                addr_ok = 1'b1;
                if (rd_setup) begin
                    state_nxt.rdata = {24'h000000, state_r.ctrl[ch]};
                end
                if (wr_en) begin
                    state_nxt.ctrl[ch] = (ch == 0 || ch == 3) ?
                        pwdata_i[7:0] :
                        pwdata_i[7:0] & `TCS_CTRL_NARROW;
                end
            end
        end
        unique case (paddr_i)
            `TCS_OFF_SYNC: begin
                addr_ok = 1'b1;
                if (rd_setup) begin
                    state_nxt.rdata = {26'h0000000, state_r.sync};
                end
                if (wr_en) begin
                    state_nxt.sync = pwdata_i[5:0] & `TCS_SYNC_MASK;
                end
            end
            `TCS_OFF_MODE: begin
                addr_ok = 1'b1;
                if (rd_setup) begin
                    state_nxt.rdata = {20'h00000, state_r.mode};
                end
                if (wr_en) begin
                    state_nxt.mode = pwdata_i[11:0] & `TCS_MODE_MASK;
                end
            end
            `TCS_OFF_STAT: begin
                addr_ok = 1'b1;
                if (rd_setup) begin
                    state_nxt.rdata = {16'h0000, state_r.s3, state_r.div};
                end
            end
            default: ;
        endcase
        if (rd_setup && !addr_ok) begin
            state_nxt.rdata = 32'h00000000;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata_o     = state_r.rdata;
    assign pready_o     = 1'b1;
    // Slave error only in the access phase so the setup cycle stays quiet
    assign pslverr_o    = psel_i & penable_i & ~addr_ok;
    assign count_en_o   = state_r.cnt_en;
    assign clear_o      = state_r.clr;
    assign phase_mode_o = state_r.mode[`TCS_MODE_PHASE_HI:`TCS_MODE_PHASE_LO];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_ch1_clear_a: assert property (
        (state_r.ctrl[1][6:5] == 2'h1 && match_i.a[1]) |=> clear_o[1])
        else $error("ch1 not cleared on A event");
    a_resv_bit_zero: assert property (
        (wr_en && paddr_i == 8'h08 && pwdata_i[7]) |=> !state_r.ctrl[2][7])
        else $error("reserved clear bit stored");
    a_sync_clear: assert property (
        (state_r.ctrl[4][6:5] == 2'h3 && state_r.sync[4] &&
         state_r.sync[1] && state_r.ctrl[1][6:5] == 2'h1 && match_i.a[1])
        |=> clear_o[4] && clear_o[1])
        else $error("sync clear missed");
    a_sync_gate: assert property (
        (state_r.ctrl[4][6:5] == 2'h3 && !state_r.sync[4]) |=> !clear_o[4])
        else $error("unsynced channel cleared");
    a_buf_blocks: assert property (
        (state_r.ctrl[0][7:5] == 3'h5 && state_r.mode[8]) |=> !clear_o[0])
        else $error("buffered C cleared counter");
    a_ch0_clear_d: assert property (
        (state_r.ctrl[0][7:5] == 3'h6 && !state_r.mode[9] && match_i.d[0])
        |=> clear_o[0])
        else $error("ch0 D clear missed");
    a_ch0_pin_a: assert property (
        (state_r.ctrl[0][4:0] == 5'h04 && state_r.s2[0] && !state_r.s3[0])
        |=> count_en_o[0])
        else $error("ch0 pin A rise not counted");
    a_ch1_ovf: assert property (
        (state_r.ctrl[1][2:0] == 3'h7 && !state_r.mode[1])
        |=> count_en_o[1] == $past(ovf_i[2]))
        else $error("ch1 overflow source wrong");
    a_ch3_4096: assert property (
        (state_r.ctrl[3][4:0] == 5'h07 && count_en_o[3] &&
         $stable(state_r.ctrl[3])) |=> !count_en_o[3] [*8])
        else $error("ch3 slow tick repeats");
    a_phase_gate: assert property (
        state_r.mode[2] |=> !count_en_o[2])
        else $error("count during phase mode");
    a_fall_edge: assert property (
        (state_r.ctrl[3][4:0] == 5'h0C && !state_r.s2[0] && state_r.s3[0])
        |=> count_en_o[3])
        else $error("falling edge not counted");
    a_pin_single: assert property (
        (state_r.ctrl[0][4:0] == 5'h04 && $stable(state_r.ctrl[0]) &&
         count_en_o[0]) |=> !count_en_o[0])
        else $error("pin edge counted twice");
    a_div_step: assert property (
        (state_r.ctrl[0][4:0] == 5'h03 && state_r.ctrl[3][4:0] == 5'h03)
        |=> count_en_o[0] == count_en_o[3])
        else $error("equal ratios out of step");
    c_sync_clear: cover property (
        state_r.sync[1] && state_r.sync[4] && clear_o[1] && clear_o[4]);
    c_ovf_count: cover property (state_r.ctrl[4][2:0] == 3'h7 && count_en_o[4]);
    c_pin_count: cover property (state_r.ctrl[5][2:0] == 3'h7 && count_en_o[5]);
    c_buf_clear: cover property (state_r.mode[10] && match_i.c[3]);
endmodule : tcs_timer_select

/* File: verilog/tcs_defs.svh */
// Register map, field positions and timing constants of the timer selector
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_NCH             6
`define TCS_OFF_CTRL_BASE   8'h00
`define TCS_OFF_CTRL_STEP   8'h04
`define TCS_OFF_SYNC        8'h18
`define TCS_OFF_MODE        8'h1C
`define TCS_OFF_STAT        8'h20

`define TCS_CCLR_HI         7
`define TCS_CCLR_LO         5
`define TCS_EDGE_HI         4
`define TCS_EDGE_LO         3
`define TCS_PSC_HI          2
`define TCS_PSC_LO          0
`define TCS_CTRL_NARROW     8'h7F
`define TCS_CTRL_RST        8'h00

`define TCS_MODE_PHASE_HI   5
`define TCS_MODE_PHASE_LO   0
`define TCS_MODE_BUFC0      8
`define TCS_MODE_BUFD0      9
`define TCS_MODE_BUFC3      10
`define TCS_MODE_BUFD3      11
`define TCS_MODE_MASK       12'hF36
`define TCS_SYNC_MASK       6'h3F

`define TCS_CLR_NONE        3'h0
`define TCS_CLR_A           3'h1
`define TCS_CLR_B           3'h2
`define TCS_CLR_SYNC_LO     2'h3
`define TCS_CLR_C           3'h5
`define TCS_CLR_D           3'h6

`define TCS_EDGE_RISE       2'h0
`define TCS_EDGE_FALL       2'h1
`define TCS_EDGE_BOTH_BIT   1

`define TCS_DIV_W           12
`define TCS_DIV4_BIT        1
`define TCS_DIV16_BIT       3
`define TCS_DIV64_BIT       5
`define TCS_DIV256_BIT      7
`define TCS_DIV1024_BIT     9
`define TCS_DIV4096_BIT     11

// Chosen ratios for internal codes left open on channels 2 and 5 (arbitrary)
`define TCS_CH2_PSC1_SRC    TCS_SRC_DIV4
`define TCS_CH2_PSC2_SRC    TCS_SRC_DIV16
`define TCS_CH2_PSC3_SRC    TCS_SRC_DIV64
`define TCS_CH2_PSC7_SRC    TCS_SRC_DIV1024
`define TCS_CH5_PSC1_SRC    TCS_SRC_DIV4

`endif

/* File: verilog/tcs_pkg.sv */
// Types shared by the timer clock and clear selector
package tcs_pkg;
    typedef enum logic [3:0] {
        TCS_SRC_DIV1, TCS_SRC_DIV4, TCS_SRC_DIV16, TCS_SRC_DIV64,
        TCS_SRC_DIV256, TCS_SRC_DIV1024, TCS_SRC_DIV4096,
        TCS_SRC_PINA, TCS_SRC_PINB, TCS_SRC_PINC, TCS_SRC_PIND,
        TCS_SRC_OVF
    } tcs_src_e;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } tcs_pins_s;

    typedef struct packed {
        logic [5:0] a;
        logic [5:0] b;
        logic [5:0] c;
        logic [5:0] d;
    } tcs_events_s;

    typedef struct packed {
        logic [5:0][7:0] ctrl;
        logic [5:0]      sync;
        logic [11:0]     mode;
        logic [3:0]      s1;
        logic [3:0]      s2;
        logic [3:0]      s3;
        logic [11:0]     div;
        logic [11:0]     div_prev;
        logic [5:0]      cnt_en;
        logic [5:0]      clr;
        logic [31:0]     rdata;
    } tcs_state_s;
endpackage : tcs_pkg

/* File: testbench/tcs_far_model.sv */
// Far side: periodic count pins, periodic overflows 2 and 5 (others random), random match events
module tcs_far_model
    import tcs_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    output tcs_pins_s   pins_o,
    output tcs_events_s match_o,
    output logic [5:0]  ovf_o
);
    logic [11:0] cyc_r;
    logic [31:0] rnd_r;
    logic [31:0] x1;
    logic [31:0] x2;
    logic [31:0] x3;

    assign x1 = rnd_r ^ (rnd_r << 13);
    assign x2 = x1 ^ (x1 >> 17);
    assign x3 = x2 ^ (x2 << 5);

    // Pins and overflows 2 and 5 are periodic so a count window has an exact answer
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cyc_r   <= 12'h000;
            rnd_r   <= 32'h2545F491;
            pins_o  <= '0;
            match_o <= '0;
            ovf_o   <= 6'h00;
        end else begin
            cyc_r   <= cyc_r + 12'h001;
            rnd_r   <= x3;
            pins_o  <= {cyc_r[4], cyc_r[5], cyc_r[6], cyc_r[3]};
            // Sparse events keep clear causes distinguishable
            match_o <= rnd_r[23:0] & x3[31:8];
            ovf_o   <= {cyc_r[7:0] == 8'h80, x3[1:0],
                        cyc_r[6:0] == 7'h00, x3[3:2]};
        end
    end
endmodule : tcs_far_model

/* File: testbench/tcs_timer_select_bench.sv */
// Self-checking bench of the timer clock and clear selector
module tcs_timer_select_bench
    import tcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W   = 8192;
    localparam int TMO = 80000;
    // Period per channel and select code; negative marks an overflow source
    localparam int PER [6][8] = '{'{1, 4, 16, 64, 32, 64, 128, 16},
                                  '{1, 4, 16, 64, 32, 64, 256, -128},
                                  '{1, 4, 16, 64, 32, 64, 128, 1024},
                                  '{1, 4, 16, 64, 32, 1024, 256, 4096},
                                  '{1, 4, 16, 64, 32, 128, 1024, -256},
                                  '{1, 4, 16, 64, 32, 128, 256, 16}};
    logic        clk_i = 1'b0;
    logic        nrst_i;
    logic        psel, pen, pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_o;
    logic        pready_o, pslverr_o;
    tcs_pins_s   pins;
    tcs_events_s match_i;
    logic [5:0]  ovf, count_en_o, clear_o, phase_mode_o, exp_q;
    logic [7:0]  ctrl_s [6];
    logic [5:0]  sync_s;
    logic [11:0] mode_s;
    logic [31:0] seed = 32'h4;
    logic        chk_on, chk_q, cnt_on;
    int          cnt [6];
    int          n_errors, tests_run, cyc;

    tcs_timer_select u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ext_pins_i(pins), .match_i(match_i),
        .ovf_i(ovf), .count_en_o(count_en_o), .clear_o(clear_o),
        .phase_mode_o(phase_mode_o));
    tcs_far_model u_far (.clk_i(clk_i), .nrst_i(nrst_i), .pins_o(pins),
        .match_o(match_i), .ovf_o(ovf));

    always #4 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [5:0] exp_clr(tcs_events_s ev);
        logic [5:0] own, res;
        logic [2:0] c;
        logic       bc, bd;
        for (int i = 0; i < 6; i++) begin
            c  = ctrl_s[i][7:5];
            bc = (i == 0) ? mode_s[8] : mode_s[10];
            bd = (i == 0) ? mode_s[9] : mode_s[11];
            case (c)
                3'h1: own[i] = ev.a[i];
                3'h2: own[i] = ev.b[i];
                3'h5: own[i] = ev.c[i] & !bc;
                3'h6: own[i] = ev.d[i] & !bd;
                default: own[i] = 1'b0;
            endcase
        end
        for (int i = 0; i < 6; i++) begin
            c      = ctrl_s[i][7:5];
            res[i] = own[i] | (c[1:0] == 2'h3 && sync_s[i] &&
                               |(own & sync_s));
        end
        return res;
    endfunction : exp_clr

    function automatic int exp_cnt(int ch);
        int p;
        p = PER[ch][ctrl_s[ch][2:0]];
        if (mode_s[ch])
            return 0;
        if (p < 0)
            return W / -p;
        if (p == 1)
            return W;
        return (ctrl_s[ch][4] ? 2 : 1) * W / p;
    endfunction : exp_cnt

    function automatic logic [31:0] rd_exp(logic [7:0] a);
        if (a < 8'h18)
            return {24'h0, ctrl_s[a[4:2]]};
        if (a == 8'h18)
            return {26'h0, sync_s};
        return {20'h0, mode_s};
    endfunction : rd_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_i);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        if (a < 8'h18)
            ctrl_s[a[4:2]] = (a == 8'h00 || a == 8'h0C) ? d[7:0]
                                                      : d[7:0] & 8'h7F;
        else if (a == 8'h18)
            sync_s = d[5:0];
        else
            mode_s = d[11:0] & 12'hF36;
    endtask : wr

    task automatic readback();
        logic [31:0] r;
        logic        e;
        for (int a = 0; a < 32; a += 4) begin
            apb(1'b0, a[7:0], 32'h0, r, e);
            chk(r, rd_exp(a[7:0]), "readback");
        end
    endtask : readback

    always @(posedge clk_i) begin
        if (chk_on && chk_q)
            chk({26'h0, clear_o}, {26'h0, exp_q}, "clear");
        chk_q <= chk_on;
        exp_q <= exp_clr(match_i);
        if (cnt_on)
            for (int i = 0; i < 6; i++)
                cnt[i] <= cnt[i] + int'(count_en_o[i]);
        cyc++;
        if (cyc == TMO) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] r;
        logic        e;
        {nrst_i, psel, pen, pwr, paddr, pwdata} = '0;
        {chk_on, chk_q, cnt_on, sync_s, mode_s} = '0;
        for (int i = 0; i < 6; i++)
            ctrl_s[i] = 8'h00;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        readback();
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(r, 32'h0, "unmapped data");
        chk({31'h0, e}, 32'h1, "unmapped error");
        apb(1'b1, 8'h44, 32'hFFFF_FFFF, r, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        // Settings change only while nothing is being judged
        for (int k = 0; k < 7; k++) begin
            // Corner settings: sync clear twice, then D clear unbuffered, then buffered C with pins
            for (int ch = 0; ch < 6; ch++)
                wr(8'(ch * 4), k == 0 ? 32'hF8 : k == 1 ? 32'hEF :
                   k == 2 ? 32'hC3 : k == 3 ? 32'hA4 : xs());
            wr(8'h18, xs());
            wr(8'h1C, k == 1 || k == 3 ? 32'hF00 : k == 2 ? 32'h36 : xs());
            readback();
            repeat (16) @(posedge clk_i);
            for (int i = 0; i < 6; i++)
                cnt[i] <= 0;
            chk_on <= 1'b1;
            cnt_on <= 1'b1;
            repeat (W) @(posedge clk_i);
            chk_on <= 1'b0;
            cnt_on <= 1'b0;
            @(posedge clk_i);
            for (int i = 0; i < 6; i++)
                chk(cnt[i], exp_cnt(i), "count");
            chk({26'h0, phase_mode_o}, {26'h0, mode_s[5:0]}, "phase");
        end
        end_sim();
    end
endmodule : tcs_timer_select_bench
